// >>> core/seew_map.svh
`ifndef SEEW_MAP_SVH
`define SEEW_MAP_SVH

// ------------------------------------------------------------
// array organisation
// ------------------------------------------------------------
`define SEEW_PAGES        64
`define SEEW_PAGE_BYTES   16
`define SEEW_ADDR_BITS    10
`define SEEW_INC_BITS     5
`define SEEW_DATA_BITS    8

// ------------------------------------------------------------
// device address word fields
// ------------------------------------------------------------
`define SEEW_DEV_TYPE_LSB 4
`define SEEW_DEV_HI_BIT   3
`define SEEW_DEV_MID_BIT  2
`define SEEW_DEV_RW_BIT   0
`define SEEW_ACK_SLOT     4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SEEW_CLK_PERIOD_NS 8
`define SEEW_WR_TIME_NS    5000000
`define SEEW_WCNT_BITS     20

`endif

// >>> core/seew_pkg.sv
`default_nettype none

package seew_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_DATA    = 3'h4,
    ST_READ    = 3'h5,
    ST_IGNORE  = 3'h6
  } seew_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic cs_hi;
    logic cs_mid;
    logic rx_tgl;
  } seew_pins_s;

endpackage

`default_nettype wire

// >>> core/seew_ram.sv
`timescale 1ns/10ps
`default_nettype none

module seew_ram #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input  wire logic                     clock, // system clock
  input  wire logic                     rstn,  // async reset, active low
  input  wire logic                     we,    // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr, // write address
  input  wire logic [WIDTH-1:0]         wdata, // write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr, // read address
  output logic      [WIDTH-1:0]         rdata  // read data, one cycle late
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("seew_ram depth must be a power of two");
  end

  always_comb begin
    rdata_next = mem_reg[raddr];
  end

  // storage has no reset, as a real array would
  always_ff @(posedge clock) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule

`default_nettype wire

// >>> core/seew_port.sv
// Summary of operation
// - sample on scl rise, drive on fall
// - open chip-select pins count as low
// - data line only pulled low or released
// - write-protect high blocks all programming
// - 64 pages of 16 bytes, 10-bit address
// - data fall with scl high is start
// - data rise with scl high is stop
// - stop after write launches programming
// - acknowledge low on ninth clock per byte
// - standby after power-up, read stop, programming
// - type code match acknowledges, else standby
// - compare bits five, six; low pin ignored
// - eighth bit selects read or program mode
// - byte write: two address bytes, one data
// - inputs ignored during self-timed programming; wp_pin still gates the array copy
// - page write up to fifteen more bytes
// - increment lower five address bits only
// - partial page programs only received bytes
// - programming completes within five milliseconds
// - no acknowledge while busy, polling allowed
`timescale 1ns/10ps
`default_nettype none
`include "seew_map.svh"

module seew_port
  import seew_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE   = 4'h6, // arbitrary value
  parameter int         PAGE_BYTES = `SEEW_PAGE_BYTES,
  parameter int         PAGES      = `SEEW_PAGES,
  parameter int         WR_CYC     = `SEEW_WR_TIME_NS / `SEEW_CLK_PERIOD_NS
) (
  input  wire logic                       clock,                // system clock
  input  wire logic                       rstn,                 // async reset, active low
  input  wire logic                       scl,                  // link clock from controller
  input  wire logic                       sda_i,                // data line level
  output logic                            sda_o,                // data line drive value
  output logic                            sda_oe,               // data line pulled low
  input  wire logic                       wp_pin,               // write protect
  input  wire logic                       chip_select_high_pin, // address strap, bit five
  input  wire logic                       chip_select_mid_pin,  // address strap, bit six
  input  wire logic                       chip_select_low_pin,  // unused strap
  input  wire logic [`SEEW_ADDR_BITS-1:0] rd_addr,              // array read address
  output logic      [`SEEW_DATA_BITS-1:0] rd_data,              // array read data
  output logic      [`SEEW_ADDR_BITS-1:0] cur_addr,             // word address counter
  output logic                            busy                  // programming running
);

  localparam int AW  = `SEEW_ADDR_BITS;
  localparam int DW  = `SEEW_DATA_BITS;
  localparam int PW  = $clog2(PAGE_BYTES);
  localparam int IW  = `SEEW_INC_BITS;
  localparam int CW  = `SEEW_WCNT_BITS;
  localparam logic [CW-1:0] WR_LAST = CW'(WR_CYC - 1);

  if (PAGES * PAGE_BYTES != 2 ** AW || PAGE_BYTES > 2 ** IW) begin : g_chk_org
    $error("seew_port page layout does not fit the address");
  end
  if (WR_CYC < PAGE_BYTES + 2 || WR_CYC >= 2 ** CW) begin : g_chk_wr
    $error("seew_port write time out of range");
  end

  // ------------------------------------------------------------
  // link domain: bit capture and data line drive
  // ------------------------------------------------------------
  logic rx_bit_reg;
  logic rx_bit_next;
  logic rx_tgl_reg;
  logic rx_tgl_next;
  logic oe_reg;
  logic oe_next;
  logic drive_req_reg;

  always_comb begin
    rx_bit_next = sda_i;
    rx_tgl_next = ~rx_tgl_reg;
    oe_next     = drive_req_reg;
  end

  // bit is held until the next rise, long after the toggle has crossed
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      rx_bit_reg <= 1'b0;
      rx_tgl_reg <= 1'b0;
    end else begin
      rx_bit_reg <= rx_bit_next;
      rx_tgl_reg <= rx_tgl_next;
    end
  end

  // request is settled during scl high, so the fall samples it stable
  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  seew_pins_s pins_raw;
  seew_pins_s sync1_reg;
  seew_pins_s sync2_reg;
  seew_pins_s prev_reg;

  always_comb begin
    pins_raw.scl    = scl;
    pins_raw.sda    = sda_i;
    pins_raw.wp     = wp_pin;
    pins_raw.cs_hi  = chip_select_high_pin;
    pins_raw.cs_mid = chip_select_mid_pin;
    pins_raw.rx_tgl = rx_tgl_reg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic wp_s;

  always_comb begin
    start_ev = prev_reg.scl & sync2_reg.scl & prev_reg.sda & ~sync2_reg.sda;
    stop_ev  = prev_reg.scl & sync2_reg.scl & ~prev_reg.sda & sync2_reg.sda;
    bit_ev   = prev_reg.rx_tgl ^ sync2_reg.rx_tgl;
    wp_s     = sync2_reg.wp;
  end

  // ------------------------------------------------------------
  // protocol state
  // ------------------------------------------------------------
  seew_state_e      state_reg;
  seew_state_e      state_next;
  logic [3:0]       bitcnt_reg;
  logic [3:0]       bitcnt_next;
  logic [6:0]       shift_reg;
  logic [6:0]       shift_next;
  logic [AW-1:0]    addr_reg;
  logic [AW-1:0]    addr_next;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [PAGE_BYTES-1:0] mask_next;
  logic [AW-PW-1:0] page_reg;
  logic [AW-PW-1:0] page_next;
  logic             drive_req_next;
  logic [DW-1:0]    byte_in;
  logic             dev_match;
  logic             buf_we;
  logic             busy_reg;

  always_comb begin
    byte_in   = {shift_reg, rx_bit_reg};
    // pads pull open straps low, so an open pin compares as zero
    dev_match = byte_in[DW-1:`SEEW_DEV_TYPE_LSB] == DEV_TYPE
              && byte_in[`SEEW_DEV_HI_BIT] == sync2_reg.cs_hi
              && byte_in[`SEEW_DEV_MID_BIT] == sync2_reg.cs_mid
              && !busy_reg;
  end

  always_comb begin
    state_next     = state_reg;
    bitcnt_next    = bitcnt_reg;
    shift_next     = shift_reg;
    addr_next      = addr_reg;
    mask_next      = mask_reg;
    page_next      = page_reg;
    drive_req_next = drive_req_reg;
    buf_we         = 1'b0;
    if (start_ev) begin
      state_next     = ST_DEVADDR;
      bitcnt_next    = 4'h0;
      drive_req_next = 1'b0;
    end else if (stop_ev) begin
      state_next     = ST_IDLE;
      bitcnt_next    = 4'h0;
      drive_req_next = 1'b0;
    end else if (bit_ev && state_reg != ST_IDLE) begin
      if (bitcnt_reg == `SEEW_ACK_SLOT) begin
        bitcnt_next    = 4'h0;
        drive_req_next = 1'b0;
      end else begin
        shift_next  = byte_in[6:0];
        bitcnt_next = bitcnt_reg + 4'h1;
        if (bitcnt_reg == `SEEW_ACK_SLOT - 4'h1) begin
          case (state_reg)
            ST_DEVADDR: begin
              if (dev_match) begin
                drive_req_next = 1'b1;
                state_next = byte_in[`SEEW_DEV_RW_BIT] ? ST_READ : ST_ADDR_HI;
              end else begin
                state_next = ST_IGNORE;
              end
            end
            ST_ADDR_HI: begin
              drive_req_next = 1'b1;
              addr_next[AW-1:DW] = byte_in[AW-DW-1:0];
              state_next = ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              drive_req_next = 1'b1;
              addr_next[DW-1:0] = byte_in;
              // page row frozen here: the five-bit count may carry into bit four
              page_next  = {addr_reg[AW-1:DW], byte_in[DW-1:PW]};
              mask_next  = '0;
              state_next = ST_DATA;
            end
            ST_DATA: begin
              drive_req_next = 1'b1;
              buf_we = 1'b1;
              mask_next[addr_reg[PW-1:0]] = 1'b1;
              addr_next[IW-1:0] = addr_reg[IW-1:0] + IW'(1);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ST_IDLE;
      bitcnt_reg    <= 4'h0;
      shift_reg     <= 7'h00;
      addr_reg      <= '0;
      mask_reg      <= '0;
      page_reg      <= '0;
      drive_req_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bitcnt_reg    <= bitcnt_next;
      shift_reg     <= shift_next;
      addr_reg      <= addr_next;
      mask_reg      <= mask_next;
      page_reg      <= page_next;
      drive_req_reg <= drive_req_next;
    end
  end

  // ------------------------------------------------------------
  // self-timed programming
  // ------------------------------------------------------------
  logic          launch;
  logic          busy_next;
  logic [CW-1:0] wcnt_reg;
  logic [CW-1:0] wcnt_next;
  logic          copy_reg;
  logic          copy_next;
  logic [PW:0]   cidx_reg;
  logic [PW:0]   cidx_next;
  logic [PW-1:0] slot;
  logic          arr_we;
  logic [AW-1:0] arr_waddr;
  logic [DW-1:0] buf_rdata;

  always_comb begin
    launch = stop_ev && state_reg == ST_DATA && |mask_reg && !wp_s && !busy_reg;
    busy_next = busy_reg;
    wcnt_next = wcnt_reg;
    copy_next = copy_reg;
    cidx_next = cidx_reg;
    if (launch) begin
      busy_next = 1'b1;
      wcnt_next = WR_LAST;
      copy_next = 1'b1;
      cidx_next = '0;
    end else if (busy_reg) begin
      if (wcnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        wcnt_next = wcnt_reg - CW'(1);
      end
      if (copy_reg) begin
        cidx_next = cidx_reg + (PW + 1)'(1);
        copy_next = cidx_reg != (PW + 1)'(PAGE_BYTES);
      end
    end
    slot      = PW'(cidx_reg - (PW + 1)'(1));
    // buffer read lags one cycle, so entry k lands while index is k+1
    arr_we    = copy_reg && cidx_reg != '0 && mask_reg[slot] && !wp_s;
    arr_waddr = {page_reg, slot};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      wcnt_reg <= '0;
      copy_reg <= 1'b0;
      cidx_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      wcnt_reg <= wcnt_next;
      copy_reg <= copy_next;
      cidx_reg <= cidx_next;
    end
  end

  seew_ram #(
    .DEPTH (PAGE_BYTES),
    .WIDTH (DW)
  ) u_page_buf (
    .clock (clock),
    .rstn  (rstn),
    .we    (buf_we),
    .waddr (addr_reg[PW-1:0]),
    .wdata (byte_in),
    .raddr (cidx_reg[PW-1:0]),
    .rdata (buf_rdata)
  );

  seew_ram #(
    .DEPTH (PAGES * PAGE_BYTES),
    .WIDTH (DW)
  ) u_array (
    .clock (clock),
    .rstn  (rstn),
    .we    (arr_we),
    .waddr (arr_waddr),
    .wdata (buf_rdata),
    .raddr (rd_addr),
    .rdata (rd_data)
  );

  assign cur_addr = addr_reg;
  assign busy     = busy_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [CW-1:0] busy_len_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_len_reg <= '0;
    end else if (busy_reg) begin
      busy_len_reg <= busy_len_reg + CW'(1);
    end else begin
      busy_len_reg <= '0;
    end
  end

  sequence s_byte_end;
    bit_ev && !start_ev && !stop_ev && state_reg != ST_IDLE
      && bitcnt_reg == `SEEW_ACK_SLOT - 4'h1;
  endsequence

  sequence s_dev_hit;
    s_byte_end ##0 state_reg == ST_DEVADDR && dev_match;
  endsequence

  a_ack_slot_only: assert property (
    @(posedge clock) disable iff (!rstn)
    drive_req_reg |-> bitcnt_reg == `SEEW_ACK_SLOT || start_ev || stop_ev)
    else $error("drive request outside acknowledge slot");

  a_start_resets: assert property (
    @(posedge clock) disable iff (!rstn)
    start_ev |=> state_reg == ST_DEVADDR && bitcnt_reg == 4'h0 && !drive_req_reg)
    else $error("start did not restart address decode");

  a_stop_standby: assert property (
    @(posedge clock) disable iff (!rstn)
    stop_ev |=> state_reg == ST_IDLE && !drive_req_reg)
    else $error("stop did not return to standby");

  a_stop_launch: assert property (
    @(posedge clock) disable iff (!rstn)
    stop_ev && state_reg == ST_DATA && |mask_reg && !wp_s && !busy_reg
      |=> busy_reg && copy_reg)
    else $error("write stop did not start programming");

  a_busy_bound: assert property (
    @(posedge clock) disable iff (!rstn)
    busy_len_reg <= CW'(WR_CYC))
    else $error("programming exceeded write time");

  a_busy_no_ack: assert property (
    @(posedge clock) disable iff (!rstn)
    s_byte_end ##0 busy_reg |=> !drive_req_reg)
    else $error("acknowledge given while programming");

  a_wp_block: assert property (
    @(posedge clock) disable iff (!rstn)
    wp_s && !busy_reg |=> !busy_reg && !arr_we)
    else $error("array written while protected");

  a_match_ack: assert property (
    @(posedge clock) disable iff (!rstn)
    s_dev_hit |=> drive_req_reg [*2])
    else $error("matching address not acknowledged");

  a_dir_select: assert property (
    @(posedge clock) disable iff (!rstn)
    s_dev_hit ##0 byte_in[`SEEW_DEV_RW_BIT]
      |=> state_reg == ST_READ)
    else $error("read bit did not select read mode");

  a_page_wrap: assert property (
    @(posedge clock) disable iff (!rstn)
    s_byte_end ##0 state_reg == ST_DATA
      |=> addr_reg[AW-1:IW] == $past(addr_reg[AW-1:IW])
        && addr_reg[IW-1:0] == $past(addr_reg[IW-1:0]) + IW'(1))
    else $error("address increment left the low bits");

  a_ack_on_fall: assert property (
    @(negedge scl) disable iff (!rstn)
    drive_req_reg |=> sda_oe)
    else $error("acknowledge not driven at scl fall");

endmodule

`default_nettype wire

// >>> bench/seew_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module seew_ctrl_model (
  output logic scl,      // link clock, stands high between frames
  output logic ctrl_low, // high = controller pulls data line low
  input  wire logic sda_i // resolved data line level
);
  initial begin
    scl      = 1'b1;
    ctrl_low = 1'b0;
  end

  // ------------------------------------------------------------
  // frame primitives, 80 ns link period
  // ------------------------------------------------------------
  task automatic bus_start();
    ctrl_low = 1'b0;
    #20 scl = 1'b1;
    #40 ctrl_low = 1'b1;
    #40 scl = 1'b0;
  endtask

  // bits msb first; data changes only while the clock is low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 ctrl_low = ~b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
    end
    #20 ctrl_low = 1'b0;
    #20 scl = 1'b1;
    #20 ack = (sda_i === 1'b0);
    #20 scl = 1'b0;
  endtask

  task automatic bus_stop();
    #20 ctrl_low = 1'b1;
    #20 scl = 1'b1;
    #40 ctrl_low = 1'b0;
    #40;
  endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import seew_pkg::*;
  localparam int WR_CYC = 400;
  logic       clock   = 1'b0;
  logic       rstn    = 1'b0;
  logic       wp_pin  = 1'b0;
  logic       cs_hi   = 1'b1;
  logic       cs_mid  = 1'b0;
  logic       cs_lo   = 1'b0;
  logic [9:0] rd_addr = 10'h000;
  logic [7:0] rd_data;
  logic [9:0] cur_addr;
  logic       busy, sda_o, sda_oe, scl, ctrl_low, sda_line, ack;
  int         fail_count      = 0;
  int         samples_checked = 0;
  // rows: {strap hi, strap mid, ack expected, device word}; type code 6 is arbitrary
  localparam logic [10:0] ROWS [6] = '{11'h568, 11'h56a, 11'h464, 11'h364, 11'h254, 11'h76d};

  always #4 clock = ~clock;
  // open drain with pull-up: low if either party pulls
  assign sda_line = ~ctrl_low & (~sda_oe | sda_o);

  seew_port #(.DEV_TYPE(4'h6), .WR_CYC(WR_CYC)) DUT (
    .clock(clock), .rstn(rstn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .wp_pin(wp_pin), .chip_select_high_pin(cs_hi), .chip_select_mid_pin(cs_mid),
    .chip_select_low_pin(cs_lo), .rd_addr(rd_addr), .rd_data(rd_data), .cur_addr(cur_addr), .busy(busy));

  seew_ctrl_model CTRL (.scl(scl), .ctrl_low(ctrl_low), .sda_i(sda_line));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic write_seq(input logic [9:0] a, input int n, input logic [7:0] d0);
    logic [7:0] b[$];
    b = '{8'h68, {6'h00, a[9:8]}, a[7:0]};
    for (int k = 0; k < n; k++) b.push_back(d0 + 8'(k));
    CTRL.bus_start();
    foreach (b[i]) begin
      CTRL.send_byte(b[i], ack);
      check(16'(ack), 16'h1, "write byte ack");
    end
    CTRL.bus_stop();
  endtask

  task automatic poll(input logic exp);
    CTRL.bus_start();
    CTRL.send_byte(8'h68, ack);
    check(16'(ack), 16'(exp), "poll ack");
    CTRL.bus_stop();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < WR_CYC + 20) begin
      @(posedge clock);
      n++;
    end
    check(16'(busy), 16'h0, "programming too long");
  endtask

  task automatic peek(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd_addr <= a;
    wait_clk(3);
    check(16'(rd_data), 16'(exp), "array word");
  endtask

  // acknowledge drive only moves while the link clock is low
  always @(sda_oe) if (rstn === 1'b1) check(16'(scl), 16'h0, "drive change with clock high");

  // generous span: all frames plus three programming cycles
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    wait_clk(5);
    rstn <= 1'b1;
    wait_clk(4);
    check(16'(cur_addr), 16'h0, "counter after reset");
    check(16'(busy), 16'h0, "busy after reset");
    check(16'(sda_oe), 16'h0, "line after reset");
    check(16'(sda_o), 16'h0, "drive value");
    $display("test reset done");
    foreach (ROWS[r]) begin
      @(posedge clock);
      cs_hi  <= ROWS[r][10];
      cs_mid <= ROWS[r][9];
      cs_lo  <= ~ROWS[r][10];
      wait_clk(4);
      CTRL.bus_start();
      CTRL.send_byte(ROWS[r][7:0], ack);
      check(16'(ack), 16'(ROWS[r][8]), "device word ack");
      CTRL.send_byte(8'h00, ack);
      check(16'(ack), 16'(ROWS[r][8] & ~ROWS[r][0]), "byte after device word");
      CTRL.bus_stop();
    end
    $display("test address table done");
    @(posedge clock);
    cs_hi  <= 1'b1;
    cs_mid <= 1'b0;
    cs_lo  <= 1'b0;
    wait_clk(4);
    write_seq(10'h123, 1, 8'h5a);
    wait_clk(3);
    check(16'(busy), 16'h1, "programming launched");
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    peek(10'h123, 8'h5a);
    check(16'(cur_addr), 16'h124, "counter after byte");
    $display("test byte write done");
    write_seq(10'h200, 17, 8'h30);
    check(16'(cur_addr), 16'h211, "counter after page");
    wait_idle();
    peek(10'h200, 8'h40);
    peek(10'h201, 8'h31);
    peek(10'h20f, 8'h3f);
    // partial page: neighbours keep the full-page values
    write_seq(10'h204, 2, 8'h70);
    check(16'(cur_addr), 16'h206, "counter after partial page");
    wait_idle();
    peek(10'h204, 8'h70);
    peek(10'h205, 8'h71);
    peek(10'h203, 8'h33);
    peek(10'h206, 8'h36);
    $display("test page write done");
    @(posedge clock);
    wp_pin <= 1'b1;
    wait_clk(4);
    write_seq(10'h123, 1, 8'ha5);
    wait_clk(3);
    check(16'(busy), 16'h0, "protected write");
    peek(10'h123, 8'h5a);
    wp_pin <= 1'b0;
    $display("test write protect done");
    // reset lands in the middle of a programming cycle
    wait_clk(4);
    write_seq(10'h130, 1, 8'h11);
    check(16'(busy), 16'h1, "programming before reset");
    @(posedge clock);
    rstn <= 1'b0;
    wait_clk(2);
    check(16'(cur_addr), 16'h0, "counter in reset");
    check(16'(sda_oe), 16'h0, "line in reset");
    check(16'(busy), 16'h0, "busy in reset");
    rstn <= 1'b1;
    wait_clk(4);
    check(16'(busy), 16'h0, "busy after second reset");
    check(16'(sda_oe), 16'h0, "line after second reset");
    poll(1'b1);
    $display("test second reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
